// >>> iobp_alu.sv
// combinational datapath: sized immediate or with flags, and bcd pack
`timescale 1ns/100ps
module iobp_alu
(
   iobp_alu_if.alu a
);
   import iobp_pkg::*;

   logic [15:0] sum;

   // -------------------------------------------------------------
   // sized or and flag results
   // -------------------------------------------------------------
   always_comb
   begin
      sum = a.pack_src + a.ext0;
      a.pack_byte = {sum[11:8], sum[3:0]};
      a.or_res = a.dst;
      a.res_neg = 1'b0;
      a.res_zero = 1'b0;
      unique case (a.size)
         IOBP_SZ_BYTE:
         begin
            // immediate is the low byte of one extension word
            a.or_res[7:0] = a.dst[7:0] | a.ext0[7:0];
            a.res_neg = a.or_res[7];
            a.res_zero = (a.or_res[7:0] == 8'h00);
         end
         IOBP_SZ_WORD:
         begin
            a.or_res[15:0] = a.dst[15:0] | a.ext0;
            a.res_neg = a.or_res[15];
            a.res_zero = (a.or_res[15:0] == 16'h0000);
         end
         default:
         begin
            // long: first extension word is the high half
            a.or_res = a.dst | {a.ext0, a.ext1};
            a.res_neg = a.or_res[31];
            a.res_zero = (a.or_res == 32'h0000_0000);
         end
      endcase
   end
endmodule

// >>> iobp_alu_if.sv
// signals between the sequencing logic and the combinational datapath
`timescale 1ns/100ps
interface iobp_alu_if;
   logic [1:0] size;
   logic [15:0] ext0;
   logic [15:0] ext1;
   logic [31:0] dst;
   logic [15:0] pack_src;
   logic [31:0] or_res;
   logic res_neg;
   logic res_zero;
   logic [7:0] pack_byte;

   modport alu (input size, ext0, ext1, dst, pack_src,
                output or_res, res_neg, res_zero, pack_byte);
   modport ctl (output size, ext0, ext1, dst, pack_src,
                input or_res, res_neg, res_zero, pack_byte);
endinterface

// >>> iobp_exec.sv
// execution unit for immediate or (data, condition byte, status word) and bcd pack
`timescale 1ns/100ps
module iobp_exec
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire logic [15:0] opcode,
   input wire logic [15:0] ext_word0,
   input wire logic [15:0] ext_word1,
   input wire logic [31:0] dest_operand,
   input wire logic [31:0] src_operand,
   input wire logic [31:0] src_addr,
   input wire logic [31:0] dst_addr,
   input wire logic [15:0] status_in,
   input wire logic supervisor_state,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy,
   output logic done,
   output logic result_we,
   output logic [31:0] result,
   output logic status_we,
   output logic [15:0] status_out,
   output logic priv_trap,
   output logic illegal_op,
   output logic mem_rd_req,
   output logic mem_wr_req,
   output logic [31:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic addr_we,
   output logic [31:0] src_addr_new,
   output logic [31:0] dst_addr_new
);
   import iobp_pkg::*;

   iobp_alu_if alu_bus();

   iobp_state_t state_reg, state_next;
   logic done_reg, done_next;
   logic result_we_reg, result_we_next;
   logic [31:0] result_reg, result_next;
   logic status_we_reg, status_we_next;
   logic [15:0] status_reg, status_next;
   logic trap_reg, trap_next;
   logic illegal_reg, illegal_next;
   logic rd_reg, rd_next;
   logic wr_reg, wr_next;
   logic [31:0] maddr_reg, maddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic addr_we_reg, addr_we_next;
   logic [31:0] sa_reg, sa_next;
   logic [31:0] da_reg, da_next;
   logic [7:0] lo_reg, lo_next;
   logic [7:0] hi_reg, hi_next;
   logic [15:0] adj_reg, adj_next;

   logic is_imor, is_ccb, is_sw, is_pack, ea_ok;
   logic [2:0] ea_mode, ea_reg;

   // -------------------------------------------------------------
   // instruction decode
   // -------------------------------------------------------------
   assign ea_mode = iobp_fld3(opcode, IOBP_MODE_LSB);
   assign ea_reg = iobp_fld3(opcode, 0);
   assign is_ccb = (opcode == IOBP_OPC_CCB);
   assign is_sw = (opcode == IOBP_OPC_SW);
   assign is_imor = (opcode[15:IOBP_HI_LSB] == IOBP_IMOR_HI) && !is_ccb && !is_sw;
   assign is_pack = (opcode[15:IOBP_TOP_LSB] == IOBP_PACK_TOP)
                    && (opcode[IOBP_HI_LSB:IOBP_MID_LSB] == IOBP_PACK_MID);
   // data alterable only: no address register, no immediate or pc-relative
   assign ea_ok = (ea_mode != IOBP_MODE_AREG)
                  && ((ea_mode != IOBP_MODE_EXT)
                      || (ea_reg == IOBP_REG_ABS_W) || (ea_reg == IOBP_REG_ABS_L));

   // -------------------------------------------------------------
   // datapath hookup; memory pack uses the latched adjustment
   // -------------------------------------------------------------
   assign alu_bus.size = iobp_size(opcode);
   assign alu_bus.ext0 = (state_reg == ST_IDLE) ? ext_word0 : adj_reg;
   assign alu_bus.ext1 = ext_word1;
   assign alu_bus.dst = dest_operand;
   assign alu_bus.pack_src = (state_reg == ST_IDLE) ? src_operand[15:0] : {hi_reg, lo_reg};

   iobp_alu u_alu
   (
      .a(alu_bus.alu)
   );

   // -------------------------------------------------------------
   // next-state and result computation
   // -------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      done_next = 1'b0;
      result_we_next = 1'b0;
      result_next = result_reg;
      status_we_next = 1'b0;
      status_next = status_reg;
      trap_next = 1'b0;
      illegal_next = 1'b0;
      rd_next = rd_reg;
      wr_next = wr_reg;
      maddr_next = maddr_reg;
      wdata_next = wdata_reg;
      addr_we_next = 1'b0;
      sa_next = sa_reg;
      da_next = da_reg;
      lo_next = lo_reg;
      hi_next = hi_reg;
      adj_next = adj_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            // start while busy is ignored: only idle looks at it
            if (start)
            begin
               status_next = status_in;
               if (is_ccb)
               begin
                  // only the low byte can change
                  status_next[7:0] = status_in[7:0] | ext_word0[7:0];
                  status_we_next = 1'b1;
                  done_next = 1'b1;
               end
               else if (is_sw)
               begin
                  if (supervisor_state)
                  begin
                     status_next = status_in | ext_word0;
                     status_we_next = 1'b1;
                  end
                  else
                     trap_next = 1'b1;
                  done_next = 1'b1;
               end
               else if (is_imor)
               begin
                  if (ea_ok && (iobp_size(opcode) != 2'b11))
                  begin
                     result_next = alu_bus.or_res;
                     result_we_next = 1'b1;
                     status_next[IOBP_FLAG_N] = alu_bus.res_neg;
                     status_next[IOBP_FLAG_Z] = alu_bus.res_zero;
                     status_next[IOBP_FLAG_V] = 1'b0;
                     status_next[IOBP_FLAG_C] = 1'b0;
                     status_we_next = 1'b1;
                  end
                  else
                     illegal_next = 1'b1;
                  done_next = 1'b1;
               end
               else if (is_pack && !opcode[IOBP_RM_BIT])
               begin
                  // register form; flags are never written by pack
                  result_next = {dest_operand[31:8], alu_bus.pack_byte};
                  result_we_next = 1'b1;
                  done_next = 1'b1;
               end
               else if (is_pack)
               begin
                  adj_next = ext_word0;
                  sa_next = src_addr - IOBP_ADDR_STEP;
                  da_next = dst_addr;
                  maddr_next = src_addr - IOBP_ADDR_STEP;
                  rd_next = 1'b1;
                  state_next = ST_RD_LO;
               end
               else
               begin
                  illegal_next = 1'b1;
                  done_next = 1'b1;
               end
            end
         end
         ST_RD_LO:
         begin
            // first byte read is the low half of the word
            if (mem_ack)
            begin
               lo_next = mem_rdata;
               sa_next = sa_reg - IOBP_ADDR_STEP;
               maddr_next = sa_reg - IOBP_ADDR_STEP;
               state_next = ST_RD_HI;
            end
         end
         ST_RD_HI:
         begin
            if (mem_ack)
            begin
               hi_next = mem_rdata;
               rd_next = 1'b0;
               state_next = ST_WR;
            end
         end
         ST_WR:
         begin
            // write request rises one cycle after the last read
            if (!wr_reg)
            begin
               da_next = da_reg - IOBP_ADDR_STEP;
               maddr_next = da_reg - IOBP_ADDR_STEP;
               wdata_next = alu_bus.pack_byte;
               wr_next = 1'b1;
            end
            else if (mem_ack)
            begin
               wr_next = 1'b0;
               addr_we_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   // -------------------------------------------------------------
   // state registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= ST_IDLE;
         done_reg <= 1'b0;
         result_we_reg <= 1'b0;
         result_reg <= 32'h0000_0000;
         status_we_reg <= 1'b0;
         status_reg <= IOBP_STATUS_RESET;
         trap_reg <= 1'b0;
         illegal_reg <= 1'b0;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         maddr_reg <= 32'h0000_0000;
         wdata_reg <= 8'h00;
         addr_we_reg <= 1'b0;
         sa_reg <= 32'h0000_0000;
         da_reg <= 32'h0000_0000;
         lo_reg <= 8'h00;
         hi_reg <= 8'h00;
         adj_reg <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         done_reg <= done_next;
         result_we_reg <= result_we_next;
         result_reg <= result_next;
         status_we_reg <= status_we_next;
         status_reg <= status_next;
         trap_reg <= trap_next;
         illegal_reg <= illegal_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         maddr_reg <= maddr_next;
         wdata_reg <= wdata_next;
         addr_we_reg <= addr_we_next;
         sa_reg <= sa_next;
         da_reg <= da_next;
         lo_reg <= lo_next;
         hi_reg <= hi_next;
         adj_reg <= adj_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign busy = (state_reg != ST_IDLE);
   assign done = done_reg;
   assign result_we = result_we_reg;
   assign result = result_reg;
   assign status_we = status_we_reg;
   assign status_out = status_reg;
   assign priv_trap = trap_reg;
   assign illegal_op = illegal_reg;
   assign mem_rd_req = rd_reg;
   assign mem_wr_req = wr_reg;
   assign mem_addr = maddr_reg;
   assign mem_wdata = wdata_reg;
   assign addr_we = addr_we_reg;
   assign src_addr_new = sa_reg;
   assign dst_addr_new = da_reg;
endmodule

// >>> iobp_mem_model.sv
// byte memory standing in for the data bus behind the block
`timescale 1ns/100ps
module iobp_mem_model
(
   input wire logic clk_sys,
   input wire logic mem_rd_req,
   input wire logic mem_wr_req,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [1:0] lag,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [16];
   logic [1:0] wait_cnt = '0;
   logic req;
   initial mem_ack = 1'h0;
   initial mem_rdata = 8'h00;
   assign req = mem_rd_req || mem_wr_req;
   // ack after lag idle cycles; read data toggles outside the ack so stale bytes never match
   always @(posedge clk_sys)
   begin
      if (req && !mem_ack && wait_cnt == lag)
      begin
         mem_ack <= 1'h1;
         mem_rdata <= mem_rd_req ? mem[mem_addr[3:0]] : ~mem_rdata;
         if (mem_wr_req)
            mem[mem_addr[3:0]] <= mem_wdata;
         wait_cnt <= 2'h0;
      end
      else
      begin
         mem_ack <= 1'h0;
         mem_rdata <= ~mem_rdata;
         wait_cnt <= (req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// >>> iobp_monitor.sv
// concurrent checks on the ports of the or/pack execution block
`timescale 1ns/100ps
module iobp_monitor
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire logic [15:0] opcode,
   input wire logic [15:0] ext_word0,
   input wire logic [31:0] dest_operand,
   input wire logic [31:0] src_operand,
   input wire logic [31:0] src_addr,
   input wire logic [15:0] status_in,
   input wire logic supervisor_state,
   input wire logic mem_ack,
   input wire logic busy,
   input wire logic done,
   input wire logic result_we,
   input wire logic [31:0] result,
   input wire logic status_we,
   input wire logic [15:0] status_out,
   input wire logic priv_trap,
   input wire logic illegal_op,
   input wire logic mem_rd_req,
   input wire logic mem_wr_req,
   input wire logic [31:0] mem_addr,
   input wire logic addr_we
);
   import iobp_pkg::*;
   // ----------------------------------------------------------
   // decode helpers and sequences
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [15:0] pack_sum;
   logic is_pack;
   logic imor_b_dn;
   // pack sum wraps at 16 bits, like the adder
   assign pack_sum = src_operand[15:0] + ext_word0;
   assign is_pack = opcode[15:12] == IOBP_PACK_TOP && opcode[8:4] == IOBP_PACK_MID;
   assign imor_b_dn = opcode[15:6] == 10'h000 && opcode[5:3] == 3'b000;
   sequence s_go;
      start && !busy;
   endsequence
   sequence s_pack_reg;
      s_go ##0 (is_pack && !opcode[3]);
   endsequence
   sequence s_pack_mem;
      s_go ##0 (is_pack && opcode[3]);
   endsequence
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   ccb_or_a: assert property (s_go ##0 opcode == IOBP_OPC_CCB
      |=> status_we && status_out == ($past(status_in) | {8'h00, $past(ext_word0[7:0])}))
      else $error("condition byte or wrong");
   sw_trap_a: assert property (s_go ##0 (opcode == IOBP_OPC_SW && !supervisor_state)
      |=> priv_trap && !status_we) else $error("user status write not trapped");
   sw_or_a: assert property (s_go ##0 (opcode == IOBP_OPC_SW && supervisor_state)
      |=> status_we && status_out == ($past(status_in) | $past(ext_word0)))
      else $error("status word or wrong");
   imor_byte_a: assert property (s_go ##0 imor_b_dn |=> result_we &&
      result == {$past(dest_operand[31:8]), $past(dest_operand[7:0]) | $past(ext_word0[7:0])})
      else $error("byte or result wrong");
   imor_flags_a: assert property (s_go ##0 imor_b_dn
      |=> status_out[3] == result[7] &&
      status_out[2] == (result[7:0] == 8'h00) && status_out[1:0] == 2'b00 &&
      status_out[4] == $past(status_in[4])) else $error("or flags wrong");
   ea_illegal_a: assert property (s_go ##0 (opcode[15:6] == 10'h000 &&
      opcode[5:3] == IOBP_MODE_AREG) |=> illegal_op && !result_we)
      else $error("address register destination accepted");
   pack_reg_a: assert property (s_pack_reg |=> result_we && !status_we &&
      result[7:0] == {$past(pack_sum[11:8]), $past(pack_sum[3:0])})
      else $error("register pack wrong");
   pack_rd_a: assert property (s_pack_mem |=> mem_rd_req &&
      mem_addr == $past(src_addr) - IOBP_ADDR_STEP) else $error("first read address wrong");
   rd_hold_a: assert property (mem_rd_req && !mem_ack
      |=> mem_rd_req && $stable(mem_addr)) else $error("read request dropped");
   wr_end_a: assert property (mem_wr_req && mem_ack
      |=> done && addr_we && !status_we && !busy) else $error("pack write not completed");
endmodule

bind iobp_exec iobp_monitor iobp_monitor_i (.clk_sys, .resetn, .start, .opcode, .ext_word0,
   .dest_operand, .src_operand, .src_addr, .status_in, .supervisor_state, .mem_ack, .busy,
   .done, .result_we, .result, .status_we, .status_out, .priv_trap, .illegal_op,
   .mem_rd_req, .mem_wr_req, .mem_addr, .addr_we);

// >>> iobp_pkg.sv
// constants, types and field helpers shared by the or/pack execution block
package iobp_pkg;

   // -------------------------------------------------------------
   // opcode decode
   // -------------------------------------------------------------
   localparam logic [15:0] IOBP_OPC_CCB = 16'h003C;
   localparam logic [15:0] IOBP_OPC_SW = 16'h007C;
   localparam logic [7:0] IOBP_IMOR_HI = 8'h00;
   localparam logic [3:0] IOBP_PACK_TOP = 4'h8;
   localparam logic [4:0] IOBP_PACK_MID = 5'h14;
   localparam int IOBP_HI_LSB = 8;
   localparam int IOBP_TOP_LSB = 12;
   localparam int IOBP_MID_LSB = 4;
   localparam int IOBP_SIZE_LSB = 6;
   localparam int IOBP_MODE_LSB = 3;
   localparam int IOBP_DREG_LSB = 9;
   localparam int IOBP_RM_BIT = 3;

   // -------------------------------------------------------------
   // operation sizes and addressing modes
   // -------------------------------------------------------------
   localparam logic [1:0] IOBP_SZ_BYTE = 2'b00;
   localparam logic [1:0] IOBP_SZ_WORD = 2'b01;
   localparam logic [1:0] IOBP_SZ_LONG = 2'b10;
   localparam logic [2:0] IOBP_MODE_AREG = 3'b001;
   localparam logic [2:0] IOBP_MODE_EXT = 3'b111;
   localparam logic [2:0] IOBP_REG_ABS_W = 3'b000;
   localparam logic [2:0] IOBP_REG_ABS_L = 3'b001;

   // -------------------------------------------------------------
   // flag positions in the condition code byte, address step and status reset value
   // -------------------------------------------------------------
   localparam int IOBP_FLAG_C = 0;
   localparam int IOBP_FLAG_V = 1;
   localparam int IOBP_FLAG_Z = 2;
   localparam int IOBP_FLAG_N = 3;
   localparam int IOBP_FLAG_X = 4;
   localparam logic [31:0] IOBP_ADDR_STEP = 32'h0000_0001;
   localparam logic [15:0] IOBP_STATUS_RESET = 16'h0000;

   typedef enum logic [1:0] {ST_IDLE, ST_RD_LO, ST_RD_HI, ST_WR} iobp_state_t;

   function automatic logic [2:0] iobp_fld3(input logic [15:0] op, input int lsb);
      iobp_fld3 = op[lsb +: 3];
   endfunction

   function automatic logic [1:0] iobp_size(input logic [15:0] op);
      iobp_size = op[IOBP_SIZE_LSB +: 2];
   endfunction

endpackage

// >>> tb.sv
// self-checking bench for the or/pack execution block
`timescale 1ns/100ps
module tb;
   import iobp_pkg::*;
   typedef struct packed {
      logic [15:0] op;
      logic [15:0] e0;
      logic [15:0] e1;
      logic [31:0] dst;
      logic [31:0] src;
      logic sup;
      logic [31:0] res;
      logic [15:0] st;
      logic [3:0] fl;
   } iobp_row_t;
   // ----------------------------------------------------------
   // stimulus, design and partner
   // ----------------------------------------------------------
   logic clk_sys = 1'h0, resetn = 1'h0, start = 1'h0, supervisor_state = 1'h0;
   logic [15:0] opcode = '0, ext_word0 = '0, ext_word1 = '0, status_in = 16'h2015;
   logic [31:0] dest_operand = '0, src_operand = '0, src_addr = '0, dst_addr = '0;
   logic [1:0] lag = '0;
   logic busy, done, result_we, status_we, priv_trap, illegal_op, addr_we;
   logic mem_rd_req, mem_wr_req, mem_ack;
   logic [31:0] result, mem_addr, src_addr_new, dst_addr_new;
   logic [15:0] status_out;
   logic [7:0] mem_rdata, mem_wdata;
   int err_total = 0, checks = 0;
   iobp_row_t r;
   logic [1:0] sw;
   logic [4:0] pulses;
   int n;
   // flags: result write, status write, trap, illegal
   localparam int NR = 14;
   localparam iobp_row_t ROWS [NR] = '{
      '{16'h0000, 16'h0080, 16'h0000, 32'h1234_5600, '0, 1'h0, 32'h1234_5680, 16'h2018, 4'hC},
      '{16'h0041, 16'h0000, 16'h0000, 32'hABCD_0000, '0, 1'h0, 32'hABCD_0000, 16'h2014, 4'hC},
      '{16'h0082, 16'h8000, 16'h0001, 32'h0000_0010, '0, 1'h0, 32'h8000_0011, 16'h2018, 4'hC},
      '{16'h0039, 16'h0001, 16'h0000, 32'h0000_00F0, '0, 1'h0, 32'h0000_00F1, 16'h2018, 4'hC},
      '{16'h0008, 16'h0001, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h1},
      '{16'h003A, 16'h0001, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h1},
      '{16'h00C0, 16'h0001, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h1},
      '{16'h003C, 16'hFF0A, 16'h0000, '0, '0, 1'h0, '0, 16'h201F, 4'h4},
      '{16'h007C, 16'h8700, 16'h0000, '0, '0, 1'h1, '0, 16'hA715, 4'h4},
      '{16'h007C, 16'h8700, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h2},
      '{16'h8342, 16'hCFD0, 16'h0000, 32'hFFFF_FF00, 32'h0000_3334, 1'h0, 32'hFFFF_FF34, '0, 4'h8},
      '{16'hFFFF, 16'h0000, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h1},
      '{16'h006D, 16'h0F00, 16'h0000, 32'h0000_F0F0, '0, 1'h0, 32'h0000_FFF0, 16'h2018, 4'hC},
      '{16'h00BC, 16'h0001, 16'h0000, '0, '0, 1'h0, '0, '0, 4'h1}};
   iobp_exec iobp_exec_i (.*);
   iobp_mem_model iobp_mem_model_i (.*);
   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // memory pack, source address 8, destination c: bytes 38 then 35, adjust cfd0
   task automatic go_mem(input logic [1:0] l);
      iobp_mem_model_i.mem[7] = 8'h38;
      iobp_mem_model_i.mem[6] = 8'h35;
      iobp_mem_model_i.mem[11] = 8'h00;
      @(posedge clk_sys);
      {opcode, ext_word0, src_addr, dst_addr} <= {16'h854B, 16'hCFD0, 32'h8, 32'hC};
      start <= 1'h1;
      lag <= l;
      @(posedge clk_sys);
      start <= 1'h0;
   endtask
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk_sys);
      chk("reset", {busy, done, result_we, status_we, mem_rd_req, result}, '0);
      resetn <= 1'h1;
      // one-cycle forms issued back to back
      for (int i = 0; i <= NR; i++)
      begin
         @(posedge clk_sys);
         start <= i < NR;
         if (i < NR)
            {opcode, ext_word0, ext_word1, dest_operand, src_operand, supervisor_state} <=
               {ROWS[i].op, ROWS[i].e0, ROWS[i].e1, ROWS[i].dst, ROWS[i].src, ROWS[i].sup};
         if (i > 0)
         begin
            @(negedge clk_sys);
            r = ROWS[i - 1];
            pulses = {done, result_we, status_we, priv_trap, illegal_op};
            chk("flags", pulses, {1'h1, r.fl});
            if (r.fl[3])
               chk("result", result, r.res);
            if (r.fl[2])
               chk("status", status_out, r.st);
         end
      end
      // memory pack with a prompt and a slow bus
      for (int l = 0; l < 3; l += 2)
      begin
         go_mem(l[1:0]);
         n = 0;
         sw = 2'h0;
         do
         begin
            @(negedge clk_sys);
            n++;
            sw |= {busy, status_we};
         end while (done !== 1'h1 && n < 40);
         // busy seen during the run and gone at done, status never written
         chk("pack done", {done, addr_we, busy, sw}, 5'h1A);
         // two reads and one write, each answered after lag plus one cycles
         chk("pack cycles", n, 5 + 3 * (l + 1));
         chk("pack byte", iobp_mem_model_i.mem[11], 8'h58);
         chk("addr new", {src_addr_new, dst_addr_new}, {32'h6, 32'hB});
      end
      // reset in mid-transfer must drop the bus request
      go_mem(2'h2);
      @(posedge clk_sys);
      resetn <= 1'h0;
      @(negedge clk_sys);
      chk("abort", {busy, mem_rd_req, mem_wr_req}, '0);
      @(posedge clk_sys);
      resetn <= 1'h1;
      // register pack right after release: nothing stale may leak in
      @(posedge clk_sys);
      r = ROWS[10];
      {opcode, ext_word0, dest_operand, src_operand} <= {r.op, r.e0, r.dst, r.src};
      start <= 1'h1;
      @(posedge clk_sys);
      start <= 1'h0;
      @(negedge clk_sys);
      pulses = {done, result_we, status_we, priv_trap, illegal_op};
      chk("pack after reset", {busy, pulses}, {1'h0, 1'h1, r.fl});
      chk("result after reset", result, r.res);
      repeat (3) @(posedge clk_sys);
      wrap_up();
   end
   // hang guard, far beyond the fewer than a hundred cycles the tests need
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      wrap_up();
   end
endmodule
